/* File: logic/acf_converter_ctrl.sv */
`timescale 1ns/1ps
`include "acf_cfg.svh"
// Contract
// RL1 - Conversion clock period is divider field plus one system clocks; field bits 7:3.
// RL2 - Ten-bit results right-justified when justify bit is 0, left-justified when 1.
// RL3 - Resolution bit 0 converts ten bits, 1 converts eight bits.
// RL4 - Eight-bit mode ignores the justify bit entirely.
// RL5 - Gain bit 0 selects gain one half, 1 selects unity gain.
// RL6 - Right-justified high byte: zeros in 7:2, top two result bits in 1:0.
// RL7 - Left-justified high byte holds the eight most significant result bits.
// RL8 - Eight-bit mode puts the whole eight-bit result in the high byte.
// RL9 - Right-justified low byte holds the eight least significant result bits.
// RL10 - Left-justified low byte: two low bits in 7:6, zeros in 5:0.
// RL11 - Eight-bit mode low byte always reads zero. Here only a completion loads zero; a software write reads back as written.
// RL12 - Busy high during conversion; its fall sets the sticky complete flag. Here only a finished conversion sets it, an abort does not.
// RL13 - Eight-bit conversion ends two conversion clocks before a ten-bit one.
// RL14 - Converter runs only while enabled; otherwise it stays shut down.
// RL15 - Both result bytes load together when the complete flag sets.
// RL16 - Writing the divider field restarts the conversion clock count.
module acf_converter_ctrl (
   // Clock, reset and clock enable
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   // Special function register port
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrEn,
   input wire logic [7:0] sfrWrData,
   input wire logic sfrRdEn,
   output logic [7:0] sfrRdData,
   // Control and status
   input wire logic converterEnable,
   input wire logic convStart,
   input wire logic flagClear,
   output logic conversionInProgress,
   output logic conversionCompleteFlag,
   // Analog core
   input wire logic compareIn,
   output logic [9:0] dacCode,
   output logic trackHold,
   output logic gainSelect,
   output logic conversionClock
);

   // ----------------------------------------
   // Reset release and input synchronisers
   // ----------------------------------------
   logic rstMeta_q;
   logic rstSync_q;
   logic cmpMeta_q;
   logic cmpSync_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else if (clkEn) begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // The comparator is analog and unrelated to the clock, so it is resampled.
   // The two-cycle delay means divider values below 2 give unsettled trials.
   always_ff @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         cmpMeta_q <= 1'b0;
         cmpSync_q <= 1'b0;
      end else if (clkEn) begin
         cmpMeta_q <= compareIn;
         cmpSync_q <= cmpMeta_q;
      end
   end

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   logic [7:0] config_q;
   logic [7:0] resLow_q;
   logic [7:0] resHigh_q;
   logic [7:0] rdData_q;
   logic [4:0] divCount_q;
   logic [4:0] divCount_d;
   logic flag_q;

   // Result writes are decoded here but lose to a completion in the same cycle.
   wire logic cfgWrite = sfrWrEn && (sfrAddr == `ACF_ADDR_CONFIG);
   wire logic lowWrite = sfrWrEn && (sfrAddr == `ACF_ADDR_RES_LOW);
   wire logic highWrite = sfrWrEn && (sfrAddr == `ACF_ADDR_RES_HIGH);
   wire logic [4:0] divField = config_q[`ACF_DIV_HI:`ACF_DIV_LO];
   wire logic justifyLeft = config_q[`ACF_JUSTIFY_BIT];
   wire logic eightBit = config_q[`ACF_RESOLUTION_BIT];

   // ----------------------------------------
   // Conversion clock divider
   // ----------------------------------------
   wire logic sarTick = (divCount_q == divField); // see RL1
   assign divCount_d = (cfgWrite || sarTick) ? 5'h00 : divCount_q + 5'h01; // see RL16

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // The sequencer owns the trial and the finished code; this block only paces
   // it with divider ticks and hands it start, enable and the resolution bit.
   acf_sar_if sarBus ();

   assign sarBus.start = convStart;
   assign sarBus.enable = converterEnable; // see RL14
   assign sarBus.tenBit = !eightBit; // see RL3
   assign sarBus.sarTick = sarTick;

   acf_sar_seq seqInst (
      .core_clk(core_clk),
      .rstSync_n(rstSync_q),
      .clkEn(clkEn),
      .sarBus(sarBus.seq),
      .compareSync(cmpSync_q),
      .dacCode(dacCode),
      .trackHold(trackHold)
   );

   // ----------------------------------------
   // Result formatting
   // ----------------------------------------
   // In eight-bit mode the low two code bits stay zero, so code[9:2] is the result.
   wire acf_pkg::acf_code_t code = sarBus.code;
   wire logic useLeft = justifyLeft && !eightBit; // see RL4
   wire logic [7:0] rightHigh = {6'h00, code[9:8]}; // see RL6
   wire logic [7:0] leftHigh = code[9:2]; // see RL7
   wire logic [7:0] rightLow = code[7:0]; // see RL9
   wire logic [7:0] leftLow = {code[1:0], 6'h00}; // see RL10
   wire logic [7:0] fmtHigh = (eightBit || useLeft) ? leftHigh : rightHigh; // see RL2 RL8
   wire logic [7:0] fmtLow = eightBit ? 8'h00 : (useLeft ? leftLow : rightLow); // see RL11

   // ----------------------------------------
   // Configuration register
   // ----------------------------------------
   // Software may rewrite the configuration mid-conversion; new bits act at once.
   always_ff @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         config_q <= `ACF_RST_CONFIG;
      end else if (clkEn && cfgWrite) begin
         config_q <= sfrWrData;
      end
   end

   // ----------------------------------------
   // Conversion clock counter
   // ----------------------------------------
   // Restarting on every write costs one long period but keeps a new divider
   // from ever waiting out a stale count of up to 32 cycles.
   always_ff @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         divCount_q <= 5'h00;
      end else if (clkEn) begin
         divCount_q <= divCount_d; // see RL16
      end
   end

   // ----------------------------------------
   // Completion flag
   // ----------------------------------------
   // The flag follows the completion pulse, which is high in the same cycle that busy
   // falls, rather than every fall of busy, so an abort leaves it untouched.
   always_ff @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         flag_q <= 1'b0;
      end else if (clkEn) begin
         // A completion in the clearing cycle wins over the clear.
         flag_q <= sarBus.done || (flag_q && !flagClear); // see RL12
      end
   end

   // ----------------------------------------
   // Read data register
   // ----------------------------------------
   // Unmapped addresses read zero so a stray read never returns stale data.
   wire logic [7:0] rdMux = (sfrAddr == `ACF_ADDR_CONFIG) ? config_q :
                            (sfrAddr == `ACF_ADDR_RES_LOW) ? resLow_q :
                            (sfrAddr == `ACF_ADDR_RES_HIGH) ? resHigh_q : 8'h00;

   always_ff @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         rdData_q <= 8'h00;
      end else if (clkEn && sfrRdEn) begin
         rdData_q <= rdMux;
      end
   end

   // ----------------------------------------
   // Result registers
   // ----------------------------------------
   // Hardware loads win over a software write in the same cycle.
   always_ff @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         resLow_q <= `ACF_RST_RESULT;
         resHigh_q <= `ACF_RST_RESULT;
      end else if (clkEn) begin
         if (sarBus.done) begin // see RL15
            resLow_q <= fmtLow;
            resHigh_q <= fmtHigh;
         end else begin
            if (lowWrite) begin
               resLow_q <= sfrWrData;
            end
            if (highWrite) begin
               resHigh_q <= sfrWrData;
            end
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign sfrRdData = rdData_q;
   assign conversionInProgress = sarBus.busy; // see RL12
   assign conversionCompleteFlag = flag_q;
   assign gainSelect = config_q[`ACF_GAIN_BIT]; // see RL5
   // The conversion clock leaves as a one-cycle tick, not a square wave, so
   // downstream logic must treat it as an enable.
   assign conversionClock = sarTick;

endmodule

/* File: logic/acf_cfg.svh */
`ifndef ACF_CFG_SVH
`define ACF_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACF_ADDR_CONFIG 8'hbc
`define ACF_ADDR_RES_LOW 8'hbd
`define ACF_ADDR_RES_HIGH 8'hbe

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACF_RST_CONFIG 8'hf9
`define ACF_RST_RESULT 8'h00

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define ACF_DIV_HI 7
`define ACF_DIV_LO 3
`define ACF_JUSTIFY_BIT 2
`define ACF_RESOLUTION_BIT 1
`define ACF_GAIN_BIT 0

// ----------------------------------------
// Conversion geometry and timing
// ----------------------------------------
`define ACF_CODE_W 10
`define ACF_LAST_BIT_10 4'h0
`define ACF_LAST_BIT_8 4'h2
`define ACF_FIRST_BIT 4'h9

`endif

/* File: logic/acf_pkg.sv */
package acf_pkg;

   // Gray codes along idle, sample, trials, finish.
   typedef enum logic [1:0] {
      ACF_IDLE = 2'b00,
      ACF_SAMPLE = 2'b01,
      ACF_TRIAL = 2'b11,
      ACF_FINISH = 2'b10
   } acf_sar_state_t;

   typedef logic [9:0] acf_code_t;

endpackage

/* File: logic/acf_sar_if.sv */
`timescale 1ns/1ps
interface acf_sar_if;
   logic start;
   logic enable;
   logic tenBit;
   logic sarTick;
   logic busy;
   logic done;
   acf_pkg::acf_code_t code;

   modport ctrl (
      output start,
      output enable,
      output tenBit,
      output sarTick,
      input busy,
      input done,
      input code
   );

   modport seq (
      input start,
      input enable,
      input tenBit,
      input sarTick,
      output busy,
      output done,
      output code
   );
endinterface

/* File: logic/acf_sar_seq.sv */
`timescale 1ns/1ps
`include "acf_cfg.svh"
module acf_sar_seq (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstSync_n,
   input wire logic clkEn,
   // Control side
   acf_sar_if.seq sarBus,
   // Analog core
   input wire logic compareSync,
   output logic [9:0] dacCode,
   output logic trackHold
);

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   acf_pkg::acf_sar_state_t state_q;
   acf_pkg::acf_sar_state_t state_d;
   logic [3:0] bitIdx_q;
   logic [3:0] bitIdx_d;
   acf_pkg::acf_code_t trial_q;
   acf_pkg::acf_code_t trial_d;
   acf_pkg::acf_code_t code_q;
   logic done_q;

   wire logic [3:0] lastBit = sarBus.tenBit ? `ACF_LAST_BIT_10 : `ACF_LAST_BIT_8;
   wire logic atLast = (bitIdx_q == lastBit);
   wire acf_pkg::acf_code_t bitMask = 10'h001 << bitIdx_q;
   wire acf_pkg::acf_code_t nextMask = 10'h001 << (bitIdx_q - 4'h1);
   wire acf_pkg::acf_code_t kept = compareSync ? trial_q : (trial_q & ~bitMask);
   wire logic finishTick = (state_q == acf_pkg::ACF_FINISH) && sarBus.sarTick;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // One sample clock, one clock per bit, one finish clock: the 8-bit
   // path stops two trials earlier and so ends two clocks sooner.
   always_comb begin
      state_d = state_q;
      bitIdx_d = bitIdx_q;
      trial_d = trial_q;
      unique case (state_q)
         acf_pkg::ACF_IDLE: begin
            if (sarBus.start && sarBus.enable) begin
               state_d = acf_pkg::ACF_SAMPLE;
            end
         end
         acf_pkg::ACF_SAMPLE: begin
            if (sarBus.sarTick) begin
               state_d = acf_pkg::ACF_TRIAL;
               bitIdx_d = `ACF_FIRST_BIT;
               trial_d = 10'h200;
            end
         end
         acf_pkg::ACF_TRIAL: begin
            if (sarBus.sarTick) begin
               if (atLast) begin // see RL13
                  state_d = acf_pkg::ACF_FINISH;
                  trial_d = kept;
               end else begin
                  bitIdx_d = bitIdx_q - 4'h1;
                  trial_d = kept | nextMask;
               end
            end
         end
         acf_pkg::ACF_FINISH: begin
            if (sarBus.sarTick) begin
               state_d = acf_pkg::ACF_IDLE;
            end
         end
      endcase
      if (!sarBus.enable) begin // see RL14
         state_d = acf_pkg::ACF_IDLE;
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_q <= acf_pkg::ACF_IDLE;
         bitIdx_q <= 4'h0;
         trial_q <= 10'h000;
         code_q <= 10'h000;
         done_q <= 1'b0;
      end else if (clkEn) begin
         state_q <= state_d;
         bitIdx_q <= bitIdx_d;
         trial_q <= trial_d;
         done_q <= finishTick && sarBus.enable;
         if (finishTick) begin
            code_q <= trial_q;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign sarBus.busy = (state_q != acf_pkg::ACF_IDLE); // see RL12
   assign sarBus.done = done_q;
   assign sarBus.code = code_q;
   assign dacCode = trial_q;
   assign trackHold = (state_q == acf_pkg::ACF_IDLE) || (state_q == acf_pkg::ACF_SAMPLE);

endmodule

/* File: test/acf_converter_ctrl_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module acf_converter_ctrl_chk (
   // Clock and reset
   input logic core_clk,
   input logic rst_n,
   // Register port
   input logic [7:0] sfrAddr,
   input logic sfrWrEn,
   input logic [7:0] sfrWrData,
   input logic sfrRdEn,
   input logic [7:0] sfrRdData,
   // Control and status
   input logic converterEnable,
   input logic convStart,
   input logic flagClear,
   input logic conversionInProgress,
   input logic conversionCompleteFlag,
   input logic gainSelect,
   input logic conversionClock
);
   logic [7:0] cfg_q;
   logic [4:0] since_q;
   logic fresh_q;
   wire cfgWr = sfrWrEn && sfrAddr == 8'hbc;
   // A write restarts the count at once; only the first period after reset is
   // skipped, since the design leaves reset two cycles after this checker.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= 8'hf9;
         since_q <= 5'h0;
         fresh_q <= 1'b1;
      end else begin
         if (cfgWr) cfg_q <= sfrWrData;
         since_q <= (conversionClock || cfgWr) ? 5'h0 : since_q + 5'h1;
         if (conversionClock) fresh_q <= 1'b0;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence sCfgWr;
      sfrWrEn && sfrAddr == 8'hbc;
   endsequence
   sequence sDone;
      $fell(conversionInProgress) && converterEnable && $past(converterEnable);
   endsequence
   a_div_period: assert property (
      conversionClock && !fresh_q |-> since_q == cfg_q[7:3]) else $error("bad tick period");
   a_done_flag: assert property (
      sDone |=> conversionCompleteFlag) else $error("flag not set");
   a_flag_sticky: assert property (
      conversionCompleteFlag && !flagClear |=> conversionCompleteFlag) else $error("flag lost");
   a_flag_clear: assert property (
      flagClear && !$fell(conversionInProgress) |=> !conversionCompleteFlag)
      else $error("flag not cleared");
   a_start_busy: assert property (
      convStart && converterEnable && !conversionInProgress |=> conversionInProgress)
      else $error("start not taken");
   a_idle_off: assert property (
      !converterEnable [*2] |-> !conversionInProgress) else $error("busy while off");
   a_gain_pin: assert property (
      sCfgWr |=> gainSelect == cfg_q[0]) else $error("gain pin wrong");
   a_unmapped_zero: assert property (
      sfrRdEn && (sfrAddr < 8'hbc || sfrAddr > 8'hbe) |=> sfrRdData == 8'h00)
      else $error("unmapped read");
   a_cfg_readback: assert property (
      sfrRdEn && sfrAddr == 8'hbc |=> sfrRdData == $past(cfg_q)) else $error("config read");
   a_abort_noflag: assert property (
      $fell(conversionInProgress) && !$past(converterEnable) && !conversionCompleteFlag
      |=> !conversionCompleteFlag) else $error("flag set by abort");
endmodule
bind acf_converter_ctrl acf_converter_ctrl_chk u_acf_converter_ctrl_chk (
   .core_clk(core_clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
   .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
   .converterEnable(converterEnable), .convStart(convStart), .flagClear(flagClear),
   .conversionInProgress(conversionInProgress),
   .conversionCompleteFlag(conversionCompleteFlag), .gainSelect(gainSelect),
   .conversionClock(conversionClock));

/* File: test/acf_analog_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Analog core model
// ----------------------------------------
module acf_analog_model (
   // Digital side
   input logic [9:0] dacCode,
   input logic trackHold,
   input logic gainSelect,
   // Input level
   input logic [9:0] vin,
   // Comparator
   output logic compareIn
);
   logic [9:0] heldLevel;
   // The level freezes when tracking stops, so input changes cannot leak in.
   always_latch begin
      if (trackHold) heldLevel <= gainSelect ? vin : {1'b0, vin[9:1]};
   end
   assign compareIn = heldLevel >= dacCode;
endmodule

/* File: test/adc_config_and_result_format_tb_top.sv */
`timescale 1ns/1ps
module adc_config_and_result_format_tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, rdVal;
   logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, converterEnable = 1'b1, convStart = 1'b0;
   logic flagClear = 1'b0, busy, flag, compareIn, trackHold, gainSelect, tick;
   logic [9:0] dacCode, vin = 10'h2d7;
   int badCount = 0, checked = 0, cyc = 0, lenTen, lenEight, lenTmp;
   initial forever #5 core_clk = ~core_clk;
   acf_converter_ctrl u_acf_converter_ctrl (.core_clk(core_clk), .rst_n(rst_n),
      .clkEn(1'b1), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
      .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .converterEnable(converterEnable),
      .convStart(convStart), .flagClear(flagClear), .conversionInProgress(busy),
      .conversionCompleteFlag(flag), .compareIn(compareIn), .dacCode(dacCode),
      .trackHold(trackHold), .gainSelect(gainSelect), .conversionClock(tick));
   acf_analog_model u_acf_analog_model (.dacCode(dacCode), .trackHold(trackHold),
      .gainSelect(gainSelect), .vin(vin), .compareIn(compareIn));
   task automatic close_out;
      $display("checked %0d bad %0d", checked, badCount);
      if (badCount == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sfrAddr <= a;
      sfrWrData <= d;
      sfrWrEn <= 1'b1;
      @(posedge core_clk);
      sfrWrEn <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      sfrAddr <= a;
      sfrRdEn <= 1'b1;
      @(posedge core_clk);
      sfrRdEn <= 1'b0;
      #1 d = sfrRdData;
   endtask
   task automatic reset_check;
      rd(8'hbc, rdVal);
      chk8(rdVal, 8'hf9);
      rd(8'hbd, rdVal);
      chk8(rdVal, 8'h00);
      rd(8'hbe, rdVal);
      chk8(rdVal, 8'h00);
      rd(8'hbf, rdVal);
      chk8(rdVal, 8'h00);
      chk1(gainSelect, 1'b1);
      wr(8'hbd, 8'h5a);
      rd(8'hbd, rdVal);
      chk8(rdVal, 8'h5a);
   endtask
   task automatic conv_check(input logic [7:0] cfg, output int len);
      logic [9:0] eff;
      logic [7:0] hi, lo;
      eff = cfg[0] ? vin : {1'b0, vin[9:1]};
      hi = (cfg[1] || cfg[2]) ? eff[9:2] : {6'h00, eff[9:8]};
      lo = cfg[1] ? 8'h00 : (cfg[2] ? {eff[1:0], 6'h00} : eff[7:0]);
      wr(8'hbc, cfg);
      @(posedge core_clk);
      convStart <= 1'b1;
      @(posedge core_clk);
      convStart <= 1'b0;
      len = 0;
      #1;
      while (busy === 1'b1 && len < 2000) begin
         @(posedge core_clk);
         #1 len++;
      end
      @(posedge core_clk);
      #1 chk1(flag, 1'b1);
      rd(8'hbe, rdVal);
      chk8(rdVal, hi);
      rd(8'hbd, rdVal);
      chk8(rdVal, lo);
      @(posedge core_clk);
      flagClear <= 1'b1;
      @(posedge core_clk);
      flagClear <= 1'b0;
      #1 chk1(flag, 1'b0);
   endtask
   task automatic enable_check;
      @(posedge core_clk);
      converterEnable <= 1'b0;
      @(posedge core_clk);
      convStart <= 1'b1;
      @(posedge core_clk);
      convStart <= 1'b0;
      @(posedge core_clk);
      #1 chk1(busy, 1'b0);
      converterEnable <= 1'b1;
      @(posedge core_clk);
      convStart <= 1'b1;
      @(posedge core_clk);
      convStart <= 1'b0;
      repeat (20) @(posedge core_clk);
      #1 chk1(busy, 1'b1);
      converterEnable <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk1(busy, 1'b0);
      chk1(flag, 1'b0);
      rd(8'hbe, rdVal);
      chk8(rdVal, 8'h01);
      converterEnable <= 1'b1;
   endtask
   // A hang must still reach the verdict.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         badCount++;
         close_out;
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      reset_check;
      conv_check(8'h19, lenTen);
      conv_check(8'h1d, lenTmp);
      conv_check(8'h1b, lenEight);
      conv_check(8'h1f, lenTmp);
      conv_check(8'h28, lenTmp);
      chk8(8'(lenTen - lenEight), 8'h08);
      enable_check;
      close_out;
   end
endmodule
